// ---- pkg/switch_reset_cfg.svh ----
/*
  offsets, field positions, reset values and timing figures of the switch reset sequencer.
  assumes a 32-bit classic wishbone slave with byte addressing and a 10 MHz core clock.
*/
`ifndef SWITCH_RESET_CFG_SVH
`define SWITCH_RESET_CFG_SVH
// register byte offsets
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define SMBS_OFS 8'h08
`define SCRATCH_OFS 8'h0c
`define GPIO_OFS 8'h10
// load-side view of per-port phy link state 0 registers, stride 4
`define PHY_LS0_BASE 8'h40
// switch control field positions
`define CTRL_FUND_BIT 0
`define CTRL_HOT_BIT 1
`define CTRL_HALT_BIT 2
`define CTRL_LDDIS_BIT 3
`define CTRL_EEDIS_BIT 4
// phy link state 0 field position
`define PHY_RETRAIN_BIT 0
// smb status field positions
`define SMBS_DONE_BIT 0
`define SMBS_ERR_BIT 1
`define SMBS_CODE_LSB 4
// status field positions
`define STAT_MODE_LSB 0
`define STAT_HALT_BIT 3
`define STAT_SLOW_BIT 4
`define STAT_ADDR_LSB 5
`define STAT_RETRY_BIT 9
`define STAT_CORE_RST_BIT 10
// reset values
`define CTRL_RST 5'h00
`define SCRATCH_RST 32'h0000_0000
`define UNMAPPED_RD 32'h0000_0000
// operating mode encodings
`define MODE_NORMAL 3'h0
`define MODE_EEPROM 3'h1
// timing
`define CLK_KHZ 10000
`define TRAIN_MS 20
`define CRS_MS 100
`define SMB_SLOW_KHZ 100
`define SMB_FAST_KHZ 400
`define HOT_HOLD_CYC 16
`endif

// ---- pkg/switch_reset_pkg.sv ----
/*
  types shared by the switch reset sequencer.
  assumes nothing beyond a systemverilog compiler.
*/
package switch_reset_pkg;
  // reset sequence steps
  typedef enum logic [3:0] {
    ST_FUND_HOLD, ST_SAMPLE, ST_PLL, ST_LINK, ST_QUASI, ST_SMB_SLAVE,
    ST_SMB_MASTER, ST_EEPROM, ST_HALT, ST_RUN, ST_HOT
  } state_t;
  // boot configuration vector
  typedef struct packed {
    logic [2:0] op_mode_sel;
    logic halt_after_reset;
    logic master_smb_slow_sel;
    logic [3:0] slave_smb_addr_pins;
  } boot_t;
  // one register write from the eeprom loader
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] data;
  } eep_wr_t;
endpackage : switch_reset_pkg

// ---- rtl/switch_reset_sequencer.sv ----
/*
  fundamental and hot reset sequencer of a four-port switch with a wishbone register slave.
  assumes pll, link, stack and eeprom loader logic on clk_i; reset and boot pins are asynchronous.
*/
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "switch_reset_cfg.svh"

// Behaviour
// - pin low or control write starts fundamental reset
// - capture boot pins on pin release only
// - mode field picks eeprom load on 0x1
// - modes: 0 normal, 1 eeprom, others reserved
// - halt pin sets status halt flag
// - quasi reset, links training within 20 ms
// - retry completions within 100 ms, others ignored
// - master smbus 100 kHz slow, 400 kHz otherwise
// - slave smbus with pin address, then master
// - eeprom load writes registers in eeprom mode
// - eeprom retrain bit write retrains port link
// - load error aborts, sets halt, records code
// - done flag on finish or error
// - halt holds logic until agent clears it
// - complete control write before warm reset
// - general pins become inputs after fundamental reset
// - ts1, link down or control bit start hot reset
// - link down disable masks only that trigger
// - up downstream links forward hot reset
// - hot reset spares pll, serdes, smbus
// - hot reset keeps sticky and unlocked fields
// - after hot reset: 20 ms train, 100 ms retry
// - hot reset reloads eeprom unless disabled
module switch_reset_sequencer #(
  parameter int N_PORTS = 4,
  parameter int GPIO_W = 8,
  parameter logic [6:0] SLAVE_ADDR_FIXED = 7'h00,
  parameter int TRAIN_CYC = `TRAIN_MS * `CLK_KHZ,
  parameter int CRS_CYC = `CRS_MS * `CLK_KHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins, asynchronous
  input wire logic ext_fund_reset_n_i,
  input wire switch_reset_pkg::boot_t boot_pins_i,
  // same-clock link and loader side
  input wire logic pll_lock_i,
  input wire logic ts1_hot_reset_i,
  input wire logic dl_down_i,
  input wire logic [N_PORTS-1:1] link_up_i,
  input wire switch_reset_pkg::eep_wr_t eep_wr_i,
  input wire logic eep_done_i,
  input wire logic eep_err_i,
  input wire logic [3:0] eep_err_code_i,
  // sequencing outputs
  output logic pll_serdes_rst_o,
  output logic link_train_en_o,
  output logic stack_rst_o,
  output logic cfg_retry_o,
  output logic core_rst_o,
  output logic slave_smb_en_o,
  output logic [6:0] slave_smb_addr_o,
  output logic master_smb_en_o,
  output logic master_smb_slow_o,
  output logic master_smb_tick_o,
  output logic eep_load_o,
  output logic [N_PORTS-1:0] retrain_o,
  output logic [N_PORTS-1:1] hot_reset_tx_o,
  output logic [GPIO_W-1:0] gpio_oe_o
);
  import switch_reset_pkg::*;

  localparam int SLOW_DIV = `CLK_KHZ / `SMB_SLOW_KHZ;
  localparam int FAST_DIV = `CLK_KHZ / `SMB_FAST_KHZ;
  localparam int HOT_CYC = `HOT_HOLD_CYC;

  logic [1:0] rstn_sync_ff; // pin synchroniser, bit 0 read only by bit 1
  boot_t boot_s1_ff; // first stage of boot pin synchroniser
  boot_t boot_s2_ff; // synchronised boot pins
  boot_t boot_ff; // vector captured at the last pin release
  logic pin_seen_ff; // fundamental reset came from the pin
  state_t state_ff;
  state_t nxt_state;
  logic [23:0] timer_ff; // cycles since the reset condition cleared
  logic timing_ff; // timer is measuring a deadline
  logic [4:0] hot_cnt_ff; // hot reset hold length
  logic hot_path_ff; // current sequence follows a hot reset
  logic pend_fund_ff; // control write seen, waiting for ack to retire
  logic pend_hot_ff;
  logic halt_ctl_ff, lddis_ff, eedis_ff;
  logic halt_stat_ff; // status copy of halt pin
  logic done_ff, err_ff;
  logic [3:0] err_code_ff;
  logic [31:0] scratch_ff;
  logic [GPIO_W-1:0] gpio_dir_ff;
  logic dl_down_q_ff, ts1_q_ff;
  logic [7:0] smb_div_ff;
  logic [7:0] gap_ff; // cycles since last smbus tick, checking only
  logic gap_seen_ff;
  logic wb_req, wb_wr, ctrl_hit;
  logic hot_trig;
  logic eep_fin;
  logic fund_entry, hot_entry;

  // wishbone request decode
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign ctrl_hit = wb_wr & wb_sel_i[0] & (wb_adr_i == `CTRL_OFS);

  // two flip-flops on every pin before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rstn_sync_ff <= 2'h0;
      boot_s1_ff <= '0;
      boot_s2_ff <= '0;
    end else begin
      rstn_sync_ff <= {rstn_sync_ff[0], ext_fund_reset_n_i};
      boot_s1_ff <= boot_pins_i;
      boot_s2_ff <= boot_s1_ff;
    end
  end

  // rising edges of the upstream triggers, so a held level fires once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dl_down_q_ff <= 1'b0;
      ts1_q_ff <= 1'b0;
    end else begin
      dl_down_q_ff <= dl_down_i;
      ts1_q_ff <= ts1_hot_reset_i;
    end
  end

  // triggers only count once the switch runs or halts; link loss during training is normal
  assign hot_trig = (ts1_hot_reset_i & ~ts1_q_ff)
                  | (dl_down_i & ~dl_down_q_ff & ~lddis_ff)
                  | (pend_hot_ff & ~wb_ack_o);
  assign eep_fin = eep_done_i | eep_err_i;

  // step sequencing; each step waits for the previous one
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_FUND_HOLD: if (rstn_sync_ff[1]) nxt_state = ST_SAMPLE;
      ST_SAMPLE: nxt_state = ST_PLL;
      // forced onward at the deadline so training is never late
      ST_PLL: if (pll_lock_i || timer_ff >= 24'(TRAIN_CYC - 2)) nxt_state = ST_LINK;
      ST_LINK: nxt_state = ST_QUASI;
      ST_QUASI: begin
        if (!hot_path_ff) nxt_state = ST_SMB_SLAVE;
        else if (boot_ff.op_mode_sel == `MODE_EEPROM && !eedis_ff) nxt_state = ST_EEPROM;
        else nxt_state = halt_ctl_ff ? ST_HALT : ST_RUN;
      end
      ST_SMB_SLAVE: nxt_state = ST_SMB_MASTER;
      ST_SMB_MASTER: begin
        // reserved modes run as plain normal mode
        if (boot_ff.op_mode_sel == `MODE_EEPROM) nxt_state = ST_EEPROM;
        else nxt_state = halt_ctl_ff ? ST_HALT : ST_RUN;
      end
      ST_EEPROM: if (eep_fin) nxt_state = (halt_ctl_ff || eep_err_i) ? ST_HALT : ST_RUN;
      ST_HALT: if (!halt_ctl_ff) nxt_state = ST_RUN;
      ST_RUN: if (hot_trig) nxt_state = ST_HOT;
      ST_HOT: if (hot_cnt_ff == 5'(HOT_CYC - 1)) nxt_state = ST_LINK;
      default: nxt_state = ST_FUND_HOLD;
    endcase
    if (state_ff == ST_HALT && hot_trig) nxt_state = ST_HOT;
    // warm reset waits until the write's ack has retired
    if (pend_fund_ff && !wb_ack_o) nxt_state = ST_FUND_HOLD;
    if (!rstn_sync_ff[1]) nxt_state = ST_FUND_HOLD;
  end

  assign fund_entry = (nxt_state == ST_FUND_HOLD);
  assign hot_entry = (nxt_state == ST_HOT) && (state_ff != ST_HOT);

  // state, path and pin-origin tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_FUND_HOLD;
      hot_path_ff <= 1'b0;
      pin_seen_ff <= 1'b1;
      hot_cnt_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      if (fund_entry) hot_path_ff <= 1'b0;
      else if (hot_entry) hot_path_ff <= 1'b1;
      // warm reset from the bit keeps the old vector
      if (!rstn_sync_ff[1]) pin_seen_ff <= 1'b1;
      else if (state_ff == ST_SAMPLE) pin_seen_ff <= 1'b0;
      hot_cnt_ff <= (state_ff == ST_HOT) ? hot_cnt_ff + 5'h01 : 5'h00;
    end
  end

  // boot vector capture on pin release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_ff <= '0;
      halt_stat_ff <= 1'b0;
    end else if (state_ff == ST_SAMPLE) begin
      if (pin_seen_ff) boot_ff <= boot_s2_ff;
      halt_stat_ff <= pin_seen_ff ? boot_s2_ff.halt_after_reset : boot_ff.halt_after_reset;
    end
  end

  // deadline timer, started when the reset condition clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_ff <= 24'h00_0000;
      timing_ff <= 1'b0;
    end else if (fund_entry || state_ff == ST_HOT) begin
      timer_ff <= 24'h00_0000;
      timing_ff <= 1'b0;
    end else if (state_ff == ST_SAMPLE || state_ff == ST_LINK && !timing_ff) begin
      timer_ff <= 24'h00_0000;
      timing_ff <= 1'b1;
    end else if (timing_ff && timer_ff != 24'hff_ffff) begin
      timer_ff <= timer_ff + 24'h00_0001;
    end
  end

  // control bits; hot reset clears halt but keeps the unlocked ones
  always_ff @(posedge clk_i) begin
    if (rst_i || fund_entry) begin
      halt_ctl_ff <= 1'(`CTRL_RST >> `CTRL_HALT_BIT);
      lddis_ff <= 1'b0;
      eedis_ff <= 1'b0;
    end else begin
      if (state_ff == ST_SAMPLE) begin
        halt_ctl_ff <= pin_seen_ff ? boot_s2_ff.halt_after_reset : boot_ff.halt_after_reset;
      end else if (state_ff == ST_EEPROM && eep_err_i) begin
        halt_ctl_ff <= 1'b1;
      end else if (hot_entry) begin
        halt_ctl_ff <= 1'b0;
      end else if (ctrl_hit) begin
        halt_ctl_ff <= wb_dat_i[`CTRL_HALT_BIT];
      end else if (state_ff == ST_EEPROM && eep_wr_i.valid && eep_wr_i.addr == `CTRL_OFS) begin
        halt_ctl_ff <= eep_wr_i.data[`CTRL_HALT_BIT];
      end
      if (ctrl_hit) begin
        lddis_ff <= wb_dat_i[`CTRL_LDDIS_BIT];
        eedis_ff <= wb_dat_i[`CTRL_EEDIS_BIT];
      end else if (state_ff == ST_EEPROM && eep_wr_i.valid && eep_wr_i.addr == `CTRL_OFS) begin
        lddis_ff <= eep_wr_i.data[`CTRL_LDDIS_BIT];
        eedis_ff <= eep_wr_i.data[`CTRL_EEDIS_BIT];
      end
    end
  end

  // self-clearing reset requests wait for the ack to retire
  always_ff @(posedge clk_i) begin
    if (rst_i || fund_entry) begin
      pend_fund_ff <= 1'b0;
      pend_hot_ff <= 1'b0;
    end else begin
      if (ctrl_hit && wb_dat_i[`CTRL_FUND_BIT]) pend_fund_ff <= 1'b1;
      if (ctrl_hit && wb_dat_i[`CTRL_HOT_BIT]) pend_hot_ff <= 1'b1;
      else if (state_ff == ST_HOT) pend_hot_ff <= 1'b0;
    end
  end

  // smbus status: smbus logic survives hot reset, so only fundamental clears it
  always_ff @(posedge clk_i) begin
    if (rst_i || fund_entry) begin
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      err_code_ff <= 4'h0;
    end else if (state_ff == ST_EEPROM && eep_fin) begin
      done_ff <= 1'b1;
      if (eep_err_i) begin
        err_ff <= 1'b1;
        err_code_ff <= eep_err_code_i;
      end
    end else if (wb_wr && wb_sel_i[0] && wb_adr_i == `SMBS_OFS) begin
      // write one clears; a finishing load above wins
      if (wb_dat_i[`SMBS_DONE_BIT]) done_ff <= 1'b0;
      if (wb_dat_i[`SMBS_ERR_BIT]) err_ff <= 1'b0;
    end
  end

  // scratch: low half plain, high half sticky, per byte lane
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_scratch
      always_ff @(posedge clk_i) begin
        if (rst_i || fund_entry || (hot_entry && gb < 2)) begin
          scratch_ff[gb*8 +: 8] <= 8'(`SCRATCH_RST >> (gb*8));
        end else if (wb_wr && wb_sel_i[gb] && wb_adr_i == `SCRATCH_OFS) begin
          scratch_ff[gb*8 +: 8] <= wb_dat_i[gb*8 +: 8];
        end
      end
    end
  endgenerate

  // general pin direction, inputs after any reset
  always_ff @(posedge clk_i) begin
    if (rst_i || fund_entry || hot_entry) gpio_dir_ff <= '0;
    else if (wb_wr && wb_sel_i[0] && wb_adr_i == `GPIO_OFS) gpio_dir_ff <= wb_dat_i[GPIO_W-1:0];
  end

  // wishbone answer one cycle after the request; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= `UNMAPPED_RD;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          `CTRL_OFS: wb_dat_o <= 32'({eedis_ff, lddis_ff, halt_ctl_ff}) << `CTRL_HALT_BIT;
          `STAT_OFS: begin
            wb_dat_o <= 32'({core_rst_o, cfg_retry_o, boot_ff.slave_smb_addr_pins,
                             boot_ff.master_smb_slow_sel, halt_stat_ff, boot_ff.op_mode_sel});
          end
          `SMBS_OFS: wb_dat_o <= 32'({err_code_ff, 2'h0, err_ff, done_ff});
          `SCRATCH_OFS: wb_dat_o <= scratch_ff;
          `GPIO_OFS: wb_dat_o <= 32'(gpio_dir_ff);
          default: wb_dat_o <= `UNMAPPED_RD;
        endcase
      end
    end
  end

  // sequencing outputs, decoded from the next state so they leave flip-flops aligned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_serdes_rst_o <= 1'b1;
      link_train_en_o <= 1'b0;
      stack_rst_o <= 1'b1;
      cfg_retry_o <= 1'b0;
      core_rst_o <= 1'b1;
      slave_smb_en_o <= 1'b0;
      master_smb_en_o <= 1'b0;
      eep_load_o <= 1'b0;
    end else begin
      // hot reset leaves pll, serdes and both smbuses alone
      pll_serdes_rst_o <= nxt_state inside {ST_FUND_HOLD, ST_SAMPLE};
      link_train_en_o <= !(nxt_state inside {ST_FUND_HOLD, ST_SAMPLE, ST_PLL, ST_HOT});
      stack_rst_o <= nxt_state inside {ST_FUND_HOLD, ST_SAMPLE, ST_PLL, ST_LINK, ST_HOT};
      cfg_retry_o <= nxt_state inside {ST_QUASI, ST_SMB_SLAVE, ST_SMB_MASTER,
                                       ST_EEPROM, ST_HALT};
      core_rst_o <= nxt_state != ST_RUN;
      if (fund_entry) slave_smb_en_o <= 1'b0;
      else if (nxt_state == ST_SMB_SLAVE) slave_smb_en_o <= 1'b1;
      if (fund_entry) master_smb_en_o <= 1'b0;
      else if (nxt_state == ST_SMB_MASTER) master_smb_en_o <= 1'b1;
      eep_load_o <= nxt_state == ST_EEPROM;
    end
  end

  // smbus setup from the captured vector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_smb_slow_o <= 1'b0;
      slave_smb_addr_o <= SLAVE_ADDR_FIXED;
    end else if (state_ff == ST_QUASI && !hot_path_ff) begin
      master_smb_slow_o <= boot_ff.master_smb_slow_sel;
      slave_smb_addr_o <= SLAVE_ADDR_FIXED;
      slave_smb_addr_o[5] <= boot_ff.slave_smb_addr_pins[3];
      slave_smb_addr_o[3:1] <= boot_ff.slave_smb_addr_pins[2:0];
    end
  end

  // master smbus bit-rate enable pulse
  always_ff @(posedge clk_i) begin
    if (rst_i || !master_smb_en_o) begin
      smb_div_ff <= 8'h00;
      master_smb_tick_o <= 1'b0;
    end else if (smb_div_ff == 8'((master_smb_slow_o ? SLOW_DIV : FAST_DIV) - 1)) begin
      smb_div_ff <= 8'h00;
      master_smb_tick_o <= 1'b1;
    end else begin
      smb_div_ff <= smb_div_ff + 8'h01;
      master_smb_tick_o <= 1'b0;
    end
  end

  // eeprom retrain writes and hot reset forwarding per port
  genvar gp;
  generate
    for (gp = 0; gp < N_PORTS; gp++) begin : g_port
      always_ff @(posedge clk_i) begin
        if (rst_i) retrain_o[gp] <= 1'b0;
        else retrain_o[gp] <= state_ff == ST_EEPROM && eep_wr_i.valid &&
                              eep_wr_i.addr == 8'(`PHY_LS0_BASE + 4*gp) &&
                              eep_wr_i.data[`PHY_RETRAIN_BIT];
      end
      if (gp > 0) begin : g_down
        always_ff @(posedge clk_i) begin
          if (rst_i) hot_reset_tx_o[gp] <= 1'b0;
          else hot_reset_tx_o[gp] <= nxt_state == ST_HOT && link_up_i[gp];
        end
      end
    end
  endgenerate

  // general pin enables follow the direction register
  always_ff @(posedge clk_i) begin
    if (rst_i) gpio_oe_o <= '0;
    else gpio_oe_o <= (fund_entry || hot_entry) ? '0 : gpio_dir_ff;
  end

  // checking only: spacing of smbus ticks
  always_ff @(posedge clk_i) begin
    if (rst_i || !master_smb_en_o) begin
      gap_ff <= 8'h00;
      gap_seen_ff <= 1'b0;
    end else if (master_smb_tick_o) begin
      gap_ff <= 8'h00;
      gap_seen_ff <= 1'b1;
    end else begin
      gap_ff <= gap_ff + 8'h01;
    end
  end

  sequence s_slave_up;
    slave_smb_en_o && !master_smb_en_o;
  endsequence
  sequence s_master_up;
    slave_smb_en_o && master_smb_en_o;
  endsequence

  a_pin_fund_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    !rstn_sync_ff[1] |=> state_ff == ST_FUND_HOLD ##1 core_rst_o && pll_serdes_rst_o)
    else $error("pin reset did not enter fundamental reset");
  a_boot_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_SAMPLE |=> boot_ff == ($past(pin_seen_ff) ? $past(boot_s2_ff) : $past(boot_ff)))
    else $error("boot vector captured wrongly");
  a_mode_select: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_SMB_MASTER && rstn_sync_ff[1] && !pend_fund_ff
    |=> (state_ff == ST_EEPROM) == ($past(boot_ff.op_mode_sel) == `MODE_EEPROM))
    else $error("operating mode chose wrong path");
  a_halt_status: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_SAMPLE && pin_seen_ff |=> halt_stat_ff == $past(boot_s2_ff.halt_after_reset))
    else $error("halt status flag not set from pin");
  a_train_deadline: assert property (@(posedge clk_i) disable iff (rst_i)
    timing_ff && timer_ff == 24'(TRAIN_CYC) |-> link_train_en_o)
    else $error("links not training at deadline");
  a_retry_deadline: assert property (@(posedge clk_i) disable iff (rst_i)
    timing_ff && timer_ff == 24'(CRS_CYC) && state_ff != ST_RUN |-> cfg_retry_o)
    else $error("retry completions not ready at deadline");
  a_smb_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    master_smb_tick_o && gap_seen_ff
    |-> gap_ff == 8'((master_smb_slow_o ? SLOW_DIV : FAST_DIV) - 1))
    else $error("master smbus rate wrong");
  a_smb_order: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(master_smb_en_o) |-> s_master_up and $past(slave_smb_en_o))
    else $error("master smbus started before slave");
  a_retrain_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_EEPROM && eep_wr_i.valid && eep_wr_i.addr == 8'(`PHY_LS0_BASE + 4)
    && eep_wr_i.data[`PHY_RETRAIN_BIT] |=> retrain_o[1])
    else $error("retrain write did not retrain port");
  a_load_error: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_EEPROM && eep_err_i && rstn_sync_ff[1] && !pend_fund_ff
    |=> halt_ctl_ff && done_ff && err_ff && state_ff == ST_HALT)
    else $error("eeprom error not handled");
  a_warm_after_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_ff == ST_FUND_HOLD) && rstn_sync_ff[1] |-> $past(pend_fund_ff) && !$past(wb_ack_o))
    else $error("warm reset began before completion");
  a_linkdown_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_RUN && lddis_ff && !ts1_hot_reset_i && !pend_hot_ff && !pend_fund_ff
    && rstn_sync_ff[1] |=> state_ff == ST_RUN)
    else $error("disabled link down caused hot reset");
  a_hot_forward: assert property (@(posedge clk_i) disable iff (rst_i)
    hot_reset_tx_o != '0 |-> state_ff == ST_HOT && !pll_serdes_rst_o && slave_smb_en_o)
    else $error("hot reset forwarded outside hot reset");
endmodule : switch_reset_sequencer

// ---- testbench/host_side_model.sv ----
/*
  far side: pll lock source and serial eeprom loader script.
  assumes the sequencer's clock; the load error is raised only on err_cmd_i.
*/
`timescale 1ns/1ps
module host_side_model (
  input wire logic clk_i,
  input wire logic pll_serdes_rst_i,
  input wire logic eep_load_i,
  input wire logic err_cmd_i,
  output logic pll_lock_o,
  output switch_reset_pkg::eep_wr_t eep_wr_o,
  output logic eep_done_o,
  output logic eep_err_o,
  output logic [3:0] eep_err_code_o
);
  import switch_reset_pkg::*;
  logic [3:0] lock_cnt_ff; // cycles since pll reset fell
  logic [3:0] step_ff; // position in the loader script
  logic wr_now;
  assign wr_now = eep_load_i && (step_ff == 4'h2);
  // lock comes some cycles late, never at once
  always_ff @(posedge clk_i) begin
    if (pll_serdes_rst_i) lock_cnt_ff <= 4'h0;
    else if (lock_cnt_ff != 4'hf) lock_cnt_ff <= lock_cnt_ff + 4'h1;
  end
  assign pll_lock_o = (lock_cnt_ff > 4'h3);
  // one retrain write to port 1, then done or error
  always_ff @(posedge clk_i) begin
    if (!eep_load_i) step_ff <= 4'h0;
    else if (step_ff != 4'hf) step_ff <= step_ff + 4'h1;
    eep_wr_o <= '{wr_now, wr_now ? 8'h44 : {4'ha, step_ff},
                  wr_now ? 32'h0000_0001 : {8{step_ff}}};
    eep_done_o <= eep_load_i && (step_ff == 4'h5) && !err_cmd_i;
    eep_err_o <= eep_load_i && (step_ff == 4'h5) && err_cmd_i;
    eep_err_code_o <= (step_ff == 4'h5) ? 4'h5 : step_ff; // idle code tracks the script step
  end
endmodule : host_side_model

// ---- testbench/test_switch_reset_sequencer.sv ----
/*
  self-checking bench of the reset sequencer: boot, registers, hot and warm resets.
  assumes a 10 MHz clock and shortened training and retry deadlines.
*/
`timescale 1ns/1ps
module test_switch_reset_sequencer;
  import switch_reset_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pin_n = 0, dl = 0, err_cmd = 0, ts1 = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic ack, lock, done, err, core, ld, pll_rst, slow, s_en, m_en, rt_seen = 0, tr, st, cr, tick;
  logic [3:0] code, rt;
  logic [2:0] hot_tx;
  logic [6:0] s_addr;
  logic [7:0] oe;
  eep_wr_t ew;
  boot_t boot = '{3'h1, 1'b0, 1'b1, 4'hb};
  int mismatches = 0, n_checks = 0, ld_cnt = 0, ld_mark = 0, gap_n = 0, gap_last = 0;
  // address, write data, expected read back
  logic [71:0] rows [4] = '{{8'h0c, 32'hdead_beef, 32'hdead_beef},
    {8'h10, 32'h0000_00ff, 32'h0000_00ff}, {8'h20, 32'h1234_5678, 32'h0000_0000},
    {8'h00, 32'h0000_0018, 32'h0000_0018}};
  initial forever #50 clk_i = ~clk_i;
  switch_reset_sequencer #(.TRAIN_CYC(40), .CRS_CYC(200)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_fund_reset_n_i(pin_n),
    .boot_pins_i(boot), .pll_lock_i(lock), .ts1_hot_reset_i(ts1), .dl_down_i(dl),
    .link_up_i(3'b101), .eep_wr_i(ew), .eep_done_i(done), .eep_err_i(err),
    .eep_err_code_i(code), .pll_serdes_rst_o(pll_rst), .link_train_en_o(tr), .stack_rst_o(st),
    .cfg_retry_o(cr), .core_rst_o(core), .slave_smb_en_o(s_en), .slave_smb_addr_o(s_addr),
    .master_smb_en_o(m_en), .master_smb_slow_o(slow), .master_smb_tick_o(tick),
    .eep_load_o(ld), .retrain_o(rt), .hot_reset_tx_o(hot_tx), .gpio_oe_o(oe));
  host_side_model partner (.clk_i(clk_i), .pll_serdes_rst_i(pll_rst), .eep_load_i(ld),
    .err_cmd_i(err_cmd), .pll_lock_o(lock), .eep_wr_o(ew), .eep_done_o(done),
    .eep_err_o(err), .eep_err_code_o(code));
  // sticky observers of short pulses; tick spacing measured edge to edge
  always @(posedge clk_i) begin
    if (ld === 1'b1) ld_cnt <= ld_cnt + 1;
    if (rt[1] === 1'b1) rt_seen <= 1'b1;
    gap_n <= (tick === 1'b1) ? 1 : gap_n + 1;
    if (tick === 1'b1) gap_last <= gap_n;
  end
  task check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  // classic single cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 100);
    if (ack !== 1'b1) mismatches++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  // bounded wait on core reset (s=0) or eeprom load (s=1)
  task wt(input int s, input logic v);
    int n;
    n = 0;
    while (((s != 0) ? ld : core) !== v && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) mismatches++;
  endtask : wt
  task complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (30000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({pll_rst, core, tr, st, cr, oe}, 13'h1a00);
    pin_n <= 1'b1;
    wt(0, 1'b0);
    check({rt_seen, slow, s_en, m_en, s_addr, tr, st, cr}, 14'h3d34);
    repeat (210) @(posedge clk_i);
    check(gap_last, 100);
    wb(0, 8'h04, 0);
    check(q[8:0], 9'h171);
    wb(0, 8'h08, 0);
    check(q[7:0], 8'h01);
    for (int i = 0; i < 4; i++) begin
      wb(1, rows[i][71:64], rows[i][63:32]);
      wb(0, rows[i][71:64], 0);
      check(q, rows[i][31:0]);
    end
    check(oe, 8'hff);
    dl <= 1'b1;
    repeat (3) @(posedge clk_i);
    dl <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(core, 1'b0);
    ld_mark = ld_cnt;
    wb(1, 8'h00, 32'h0000_001a);
    wt(0, 1'b1);
    repeat (3) @(posedge clk_i);
    check({hot_tx, pll_rst, s_en, m_en, tr, st}, 8'had);
    wt(0, 1'b0);
    check({ld_cnt != ld_mark, oe}, 9'h000);
    wb(0, 8'h0c, 0);
    check(q, 32'hdead_0000);
    wb(0, 8'h00, 0);
    check(q, 32'h0000_0018);
    err_cmd <= 1'b1;
    boot <= '{3'h0, 1'b1, 1'b0, 4'h0};
    wb(1, 8'h00, 32'h0000_0001);
    wt(1, 1'b1);
    wt(1, 1'b0);
    repeat (3) @(posedge clk_i);
    check({core, tr, st, cr}, 4'hd);
    wb(0, 8'h08, 0);
    check(q[7:0], 8'h53);
    wb(0, 8'h00, 0);
    check(q, 32'h0000_0004);
    wb(0, 8'h04, 0);
    check(q[2:0], 3'h1);
    wb(1, 8'h00, 32'h0000_0000);
    wt(0, 1'b0);
    check(core, 1'b0);
    err_cmd <= 1'b0;
    ld_mark = ld_cnt;
    ts1 <= 1'b1;
    wt(0, 1'b1);
    ts1 <= 1'b0;
    check(hot_tx, 3'h5);
    wt(0, 1'b0);
    check(ld_cnt != ld_mark, 1'b1);
    complete_run();
  end
endmodule : test_switch_reset_sequencer
